// File: logic/ecr_consts.svh
// Offsets, field positions and reset values for the extended capability registers
// What this block does
// R1 - The fourth header-log word is read-only to software, sticky, holds header word four of the first uncorrectable error, resets to zero.
// R2 - The serial number header reads a fixed identifier of 3 in bits 15:0.
// R3 - Both capability headers read a fixed version of 1 in bits 19:16.
// R4 - Each header holds a next-capability link in bits 31:20, reset zero, written only through the lockable path.
// R5 - The low serial number word holds EUI-64 bits 31:0, sticky, lockable-writable, reset zero.
// R6 - The high serial number word holds EUI-64 bits 63:32, sticky, lockable-writable, reset zero.
// R7 - The virtual channel header reads a fixed identifier of 2 in bits 15:0.
// R8 - The extended channel count in bits 2:0 of the port channel word reads zero.
// R9 - The low-priority channel count in bits 6:4 reads zero.
// R10 - The arbitration time base in bits 9:8 reads zero.
// R11 - The entry size in bits 11:10 reads 2 on the upstream port and 0 on downstream ports.
// R12 - Entry size codes 0 to 3 stand for 1, 2, 4 and 8 bit entries.
// R13 - Reserved bits read zero and writes to them are ignored.
`ifndef ECR_CONSTS_SVH
`define ECR_CONSTS_SVH
// ==========================================
// Offsets
`define ECR_OFF_HDR_LOG4 12'h128
`define ECR_OFF_SN_HDR 12'h180
`define ECR_OFF_SN_LOW 12'h184
`define ECR_OFF_SN_HIGH 12'h188
`define ECR_OFF_VC_HDR 12'h200
`define ECR_OFF_PORT_CAP1 12'h204
`define ECR_OFF_LOCK_CTRL 12'h300
// ==========================================
// Field values
`define ECR_SN_CAP_ID 16'h0003
`define ECR_VC_CAP_ID 16'h0002
`define ECR_CAP_VERSION 4'h1
`define ECR_LINK_RESET 12'h000
`define ECR_WORD_RESET 32'h00000000
`define ECR_CHAN_COUNT 3'h0
`define ECR_LP_CHAN_COUNT 3'h0
`define ECR_TIME_BASE 2'h0
`define ECR_ENTRY_UP 2'h2
`define ECR_ENTRY_DOWN 2'h0
// ==========================================
// Field positions
`define ECR_LINK_MSB 31
`define ECR_LINK_LSB 20
`endif

// File: logic/ecr_pkg.sv
// Types for the extended capability registers
package ecr_pkg;
   typedef logic [11:0] ecr_addr_t;
   typedef logic [31:0] ecr_word_t;
endpackage

// File: logic/ecr_regs.sv
// Extended capability register bank
`timescale 1ns/1ns
`default_nettype none
`include "ecr_consts.svh"
module ecr_regs
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic sticky_rstn,
   input wire logic upstream_port,
   input wire ecr_pkg::ecr_addr_t addr,
   input wire ecr_pkg::ecr_word_t wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic log_valid,
   input wire ecr_pkg::ecr_word_t log_word4,
   input wire logic log_clear,
   output ecr_pkg::ecr_word_t rdata,
   output logic lock_open
);
   import ecr_pkg::*;
   // ==========================================
   // State
   ecr_word_t hdr_log4_reg;
   logic log_held_reg;
   logic [11:0] sn_link_reg;
   logic [11:0] vc_link_reg;
   ecr_word_t sn_low_reg;
   ecr_word_t sn_high_reg;
   logic lock_open_reg;
   ecr_word_t rdata_reg;
   ecr_word_t rdata_next;
   logic lock_wr;
   logic port_sync1_reg;
   logic port_sync2_reg;
   logic port_sync3_reg;
   logic upstream_reg;

   // ==========================================
   // Helpers
   // Header word: link on top, fixed version, fixed identifier
   function automatic ecr_word_t cap_header(input logic [11:0] link, input logic [15:0] cap_id);
      cap_header = {link, `ECR_CAP_VERSION, cap_id}; // [R3]
   endfunction

   // Link field of a header write; the rest of the word is fixed or reserved
   function automatic logic [11:0] link_field(input ecr_word_t data);
      link_field = data[`ECR_LINK_MSB:`ECR_LINK_LSB]; // [R4] [R13]
   endfunction

   // One strobe aimed at one offset
   function automatic logic addr_hit(input logic strobe, input ecr_addr_t a, input ecr_addr_t off);
      addr_hit = strobe && (a == off);
   endfunction

   // Lockable fields take writes only while the lock is open
   assign lock_wr = wr && lock_open_reg;

   // ==========================================
   // Header log, first error only; sticky reset keeps it over a hot reset
   always_ff @(posedge clk or negedge sticky_rstn)
   begin
      if (!sticky_rstn)
      begin
         hdr_log4_reg <= `ECR_WORD_RESET;
         log_held_reg <= 1'b0;
      end
      else if (log_valid && !log_held_reg)
      begin
         hdr_log4_reg <= log_word4; // [R1]
         log_held_reg <= 1'b1;
      end
      else if (log_clear)
      begin
         log_held_reg <= 1'b0;
      end
   end

   // ==========================================
   // Lock control, opens writes to lockable fields
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         lock_open_reg <= 1'b0;
      else if (addr_hit(wr, addr, `ECR_OFF_LOCK_CTRL))
         lock_open_reg <= wdata[0]; // [R4]
   end

   // ==========================================
   // Port role strap, three flops deep
   // Entry size lags the strap by four clocks and reads downstream just after reset
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         port_sync1_reg <= 1'b0;
         port_sync2_reg <= 1'b0;
         port_sync3_reg <= 1'b0;
      end
      else
      begin
         port_sync1_reg <= upstream_port;
         port_sync2_reg <= port_sync1_reg;
         port_sync3_reg <= port_sync2_reg;
      end
   end

   // Taken only once two late stages agree, so a one-clock glitch never reaches a read
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         upstream_reg <= 1'b0;
      else if (port_sync2_reg == port_sync3_reg)
         upstream_reg <= port_sync3_reg; // [R11]
   end

   // ==========================================
   // Next-capability links
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sn_link_reg <= `ECR_LINK_RESET;
         vc_link_reg <= `ECR_LINK_RESET;
      end
      else if (addr_hit(lock_wr, addr, `ECR_OFF_SN_HDR))
         sn_link_reg <= link_field(wdata); // [R4]
      else if (addr_hit(lock_wr, addr, `ECR_OFF_VC_HDR))
         vc_link_reg <= link_field(wdata); // [R4]
   end

   // ==========================================
   // Serial number, sticky
   always_ff @(posedge clk or negedge sticky_rstn)
   begin
      if (!sticky_rstn)
      begin
         sn_low_reg <= `ECR_WORD_RESET;
         sn_high_reg <= `ECR_WORD_RESET;
      end
      else if (addr_hit(lock_wr, addr, `ECR_OFF_SN_LOW))
         sn_low_reg <= wdata; // [R5]
      else if (addr_hit(lock_wr, addr, `ECR_OFF_SN_HIGH))
         sn_high_reg <= wdata; // [R6]
   end

   // ==========================================
   // Read decode
   always_comb
   begin
      rdata_next = `ECR_WORD_RESET;
      unique case (addr)
         `ECR_OFF_HDR_LOG4: rdata_next = hdr_log4_reg; // [R1]
         `ECR_OFF_SN_HDR: rdata_next = cap_header(sn_link_reg, `ECR_SN_CAP_ID); // [R2] [R3] [R4]
         `ECR_OFF_SN_LOW: rdata_next = sn_low_reg; // [R5]
         `ECR_OFF_SN_HIGH: rdata_next = sn_high_reg; // [R6]
         `ECR_OFF_VC_HDR: rdata_next = cap_header(vc_link_reg, `ECR_VC_CAP_ID); // [R7] [R3]
         `ECR_OFF_PORT_CAP1:
            // Code 2 selects 4-bit entries [R12]
            rdata_next = {20'h00000, (upstream_reg ? `ECR_ENTRY_UP : `ECR_ENTRY_DOWN), // [R11]
                          `ECR_TIME_BASE, 1'b0, `ECR_LP_CHAN_COUNT, 1'b0, `ECR_CHAN_COUNT}; // [R8] [R9] [R10] [R13]
         `ECR_OFF_LOCK_CTRL: rdata_next = {31'h00000000, lock_open_reg};
         default: rdata_next = `ECR_WORD_RESET; // [R13]
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rdata_reg <= `ECR_WORD_RESET;
      else if (rd)
         rdata_reg <= rdata_next;
      else
         rdata_reg <= `ECR_WORD_RESET;
   end

   assign rdata = rdata_reg;
   assign lock_open = lock_open_reg;

   // ==========================================
   // Checks
   property p_sn_hdr_const;
      @(posedge clk) disable iff (!rstn)
      (rd && addr == `ECR_OFF_SN_HDR) |=> (rdata[19:0] == 20'h10003);
   endproperty
   a_sn_hdr_const: assert property (p_sn_hdr_const) else $error("serial header id or version wrong"); // [R2]

   property p_vc_hdr_const;
      @(posedge clk) disable iff (!rstn)
      (rd && addr == `ECR_OFF_VC_HDR) |=> (rdata[19:0] == 20'h10002);
   endproperty
   a_vc_hdr_const: assert property (p_vc_hdr_const) else $error("vc header id or version wrong"); // [R7]

   property p_cap_version;
      @(posedge clk) disable iff (!rstn)
      (rd && (addr == `ECR_OFF_SN_HDR || addr == `ECR_OFF_VC_HDR)) |=> (rdata[19:16] == 4'h1);
   endproperty
   a_cap_version: assert property (p_cap_version) else $error("capability version not one"); // [R3]

   sequence s_locked_link_write;
      wr && !lock_open_reg && addr == `ECR_OFF_SN_HDR;
   endsequence
   property p_link_locked;
      @(posedge clk) disable iff (!rstn)
      s_locked_link_write |=> $stable(sn_link_reg);
   endproperty
   a_link_locked: assert property (p_link_locked) else $error("link changed while locked"); // [R4]

   property p_sn_low_write;
      @(posedge clk) disable iff (!rstn || !sticky_rstn)
      (lock_wr && addr == `ECR_OFF_SN_LOW) |=> (sn_low_reg == $past(wdata));
   endproperty
   a_sn_low_write: assert property (p_sn_low_write) else $error("low serial word not written"); // [R5]

   property p_sn_high_read;
      @(posedge clk) disable iff (!rstn || !sticky_rstn)
      (rd && addr == `ECR_OFF_SN_HIGH) |=> (rdata == $past(sn_high_reg));
   endproperty
   a_sn_high_read: assert property (p_sn_high_read) else $error("high serial word read wrong"); // [R6]

   property p_port_cap1;
      @(posedge clk) disable iff (!rstn)
      (rd && addr == `ECR_OFF_PORT_CAP1) |=>
         (rdata[9:0] == 10'h000 && rdata[31:12] == 20'h00000 && rdata[11:10] == ($past(upstream_reg) ? 2'h2 : 2'h0));
   endproperty
   a_port_cap1: assert property (p_port_cap1) else $error("port channel word wrong"); // [R8]

   property p_log_first;
      @(posedge clk) disable iff (!sticky_rstn)
      (log_held_reg && !log_clear) |=> $stable(hdr_log4_reg);
   endproperty
   a_log_first: assert property (p_log_first) else $error("header log overwritten"); // [R1]

   property p_unmapped_zero;
      @(posedge clk) disable iff (!rstn)
      (rd && addr == 12'h18C) |=> (rdata == 32'h00000000);
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero"); // [R13]

   // ==========================================
   // Header log checks
   property p_log_capture;
      @(posedge clk) disable iff (!sticky_rstn)
      (log_valid && !log_held_reg) |=> (hdr_log4_reg == $past(log_word4));
   endproperty
   a_log_capture: assert property (p_log_capture) else $error("header log not captured"); // [R1]

   property p_log_release;
      @(posedge clk) disable iff (!sticky_rstn)
      (log_clear && log_held_reg) |=> !log_held_reg;
   endproperty
   a_log_release: assert property (p_log_release) else $error("header log not released"); // [R1]

   property p_log_capture_wins;
      @(posedge clk) disable iff (!sticky_rstn)
      (log_valid && log_clear && !log_held_reg) |=> log_held_reg;
   endproperty
   a_log_capture_wins: assert property (p_log_capture_wins) else $error("clear beat a capture"); // [R1]

   property p_log_read;
      @(posedge clk) disable iff (!rstn || !sticky_rstn)
      (rd && addr == `ECR_OFF_HDR_LOG4) |=> (rdata == $past(hdr_log4_reg));
   endproperty
   a_log_read: assert property (p_log_read) else $error("header log read wrong"); // [R1]

   // ==========================================
   // Lockable link checks
   sequence s_locked_vc_write;
      wr && !lock_open_reg && addr == `ECR_OFF_VC_HDR;
   endsequence
   property p_vc_link_locked;
      @(posedge clk) disable iff (!rstn)
      s_locked_vc_write |=> $stable(vc_link_reg);
   endproperty
   a_vc_link_locked: assert property (p_vc_link_locked) else $error("vc link changed while locked"); // [R4]

   sequence s_open_sn_link_write;
      lock_wr && addr == `ECR_OFF_SN_HDR;
   endsequence
   property p_sn_link_write;
      @(posedge clk) disable iff (!rstn)
      s_open_sn_link_write |=> (sn_link_reg == $past(wdata[`ECR_LINK_MSB:`ECR_LINK_LSB]));
   endproperty
   a_sn_link_write: assert property (p_sn_link_write) else $error("serial link not written"); // [R4]

   sequence s_open_vc_link_write;
      lock_wr && addr == `ECR_OFF_VC_HDR;
   endsequence
   property p_vc_link_write;
      @(posedge clk) disable iff (!rstn)
      s_open_vc_link_write |=> (vc_link_reg == $past(wdata[`ECR_LINK_MSB:`ECR_LINK_LSB]));
   endproperty
   a_vc_link_write: assert property (p_vc_link_write) else $error("vc link not written"); // [R4]

   // ==========================================
   // Serial number checks
   property p_sn_low_locked;
      @(posedge clk) disable iff (!rstn || !sticky_rstn)
      (wr && !lock_open_reg && addr == `ECR_OFF_SN_LOW) |=> $stable(sn_low_reg);
   endproperty
   a_sn_low_locked: assert property (p_sn_low_locked) else $error("low serial word changed while locked"); // [R5]

   property p_sn_high_locked;
      @(posedge clk) disable iff (!rstn || !sticky_rstn)
      (wr && !lock_open_reg && addr == `ECR_OFF_SN_HIGH) |=> $stable(sn_high_reg);
   endproperty
   a_sn_high_locked: assert property (p_sn_high_locked) else $error("high serial word changed while locked"); // [R6]

   property p_sn_high_write;
      @(posedge clk) disable iff (!rstn || !sticky_rstn)
      (lock_wr && addr == `ECR_OFF_SN_HIGH) |=> (sn_high_reg == $past(wdata));
   endproperty
   a_sn_high_write: assert property (p_sn_high_write) else $error("high serial word not written"); // [R6]

   property p_sn_low_read;
      @(posedge clk) disable iff (!rstn || !sticky_rstn)
      (rd && addr == `ECR_OFF_SN_LOW) |=> (rdata == $past(sn_low_reg));
   endproperty
   a_sn_low_read: assert property (p_sn_low_read) else $error("low serial word read wrong"); // [R5]

   // ==========================================
   // Port channel word and lock word checks
   property p_low_prio_count;
      @(posedge clk) disable iff (!rstn)
      (rd && addr == `ECR_OFF_PORT_CAP1) |=> (rdata[6:4] == `ECR_LP_CHAN_COUNT);
   endproperty
   a_low_prio_count: assert property (p_low_prio_count) else $error("low priority count not zero"); // [R9]

   property p_time_base;
      @(posedge clk) disable iff (!rstn)
      (rd && addr == `ECR_OFF_PORT_CAP1) |=> (rdata[9:8] == `ECR_TIME_BASE);
   endproperty
   a_time_base: assert property (p_time_base) else $error("time base not zero"); // [R10]

   property p_entry_size;
      @(posedge clk) disable iff (!rstn)
      (rd && addr == `ECR_OFF_PORT_CAP1) |=> (rdata[11:10] == ($past(upstream_reg) ? `ECR_ENTRY_UP : `ECR_ENTRY_DOWN));
   endproperty
   a_entry_size: assert property (p_entry_size) else $error("entry size wrong for port role"); // [R11]

   property p_lock_reads_zero;
      @(posedge clk) disable iff (!rstn)
      (rd && addr == `ECR_OFF_LOCK_CTRL) |=> (rdata[31:1] == 31'h00000000);
   endproperty
   a_lock_reads_zero: assert property (p_lock_reads_zero) else $error("lock word spare bits not zero"); // [R13]
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the extended capability register bank
`timescale 1ns/1ns
`default_nettype none
`include "ecr_consts.svh"
module tb;
   import ecr_pkg::*;
   // ==========================================
   // Signals and model state
   logic clk, rstn, sticky_rstn, upstream_port, wr, rd, log_valid, log_clear, lock_open;
   ecr_addr_t addr;
   ecr_word_t wdata, log_word4, rdata, m_log, m_lo, m_hi;
   logic [11:0] m_lsn, m_lvc;
   logic m_lock, m_held;
   int errors, checked, cycles, seed;
   ecr_addr_t addrs [9] = '{12'h128, 12'h180, 12'h184, 12'h188, 12'h200, 12'h204, 12'h3FC, 12'h18C, 12'h300};
   ecr_regs dut (.clk(clk), .rstn(rstn), .sticky_rstn(sticky_rstn), .upstream_port(upstream_port),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .log_valid(log_valid), .log_word4(log_word4),
      .log_clear(log_clear), .rdata(rdata), .lock_open(lock_open));
   initial
   begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   // Hang guard, run needs well under a thousand cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         wrap_up();
      end
   end
   // ==========================================
   // Model and tasks
   function automatic ecr_word_t model(ecr_addr_t a);
      case (a)
         12'h128: return m_log;
         12'h180: return {m_lsn, 4'h1, 16'h0003};
         12'h184: return m_lo;
         12'h188: return m_hi;
         12'h200: return {m_lvc, 4'h1, 16'h0002};
         12'h204: return upstream_port ? 32'h00000800 : 32'h00000000;
         12'h300: return {31'h0, m_lock};
         default: return 32'h00000000;
      endcase
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic write(input ecr_addr_t a, input ecr_word_t d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      // Lock state before this write decides whether it lands
      if (m_lock && a == 12'h180) m_lsn = d[31:20];
      if (m_lock && a == 12'h200) m_lvc = d[31:20];
      if (m_lock && a == 12'h184) m_lo = d;
      if (m_lock && a == 12'h188) m_hi = d;
      if (a == 12'h300) m_lock = d[0];
   endtask
   task automatic rd_chk(input ecr_addr_t a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata, model(a));
   endtask
   task automatic sweep();
      foreach (addrs[i]) rd_chk(addrs[i]);
   endtask
   task automatic log_evt(input logic v, input logic c);
      ecr_word_t w;
      w = $urandom;
      @(posedge clk);
      log_valid <= v;
      log_clear <= c;
      log_word4 <= w;
      @(posedge clk);
      log_valid <= 1'b0;
      log_clear <= 1'b0;
      if (v && !m_held) {m_log, m_held} = {w, 1'b1};
      else if (c) m_held = 1'b0;
   endtask
   task automatic do_reset(input logic full);
      @(posedge clk);
      rstn <= 1'b0;
      sticky_rstn <= !full;
      repeat (10) @(posedge clk);
      {rstn, sticky_rstn} <= 2'b11;
      {m_lock, m_lsn, m_lvc} = '0;
      if (full) {m_log, m_lo, m_hi, m_held} = '0;
      #1 check({31'h0, lock_open}, 32'h0);
   endtask
   task automatic wrap_up();
      if (errors == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial
   begin
      {rstn, sticky_rstn, wr, rd, log_valid, log_clear, addr, wdata, log_word4} = '0;
      upstream_port = 1'b1;
      {m_lock, m_lsn, m_lvc, m_log, m_lo, m_hi, m_held} = '0;
      seed = $urandom(28033);
      repeat (10) @(posedge clk);
      {rstn, sticky_rstn} <= 2'b11;
      sweep();
      // Closed then open lock, every writable and read-only place hit with random data
      for (int k = 0; k < 4; k++)
      begin
         write(12'h300, {31'($urandom), k[0]});
         foreach (addrs[i]) write(addrs[i], $urandom);
         sweep();
      end
      log_evt(1'b1, 1'b0);
      log_evt(1'b1, 1'b0);
      rd_chk(12'h128);
      log_evt(1'b0, 1'b1);
      log_evt(1'b1, 1'b0);
      rd_chk(12'h128);
      log_evt(1'b0, 1'b1);
      log_evt(1'b1, 1'b1);
      rd_chk(12'h128);
      // Strap passes three flops and then upstream_reg, so give it four clocks to settle
      @(posedge clk);
      upstream_port <= 1'b0;
      repeat (4) @(posedge clk);
      rd_chk(12'h204);
      @(posedge clk);
      upstream_port <= 1'b1;
      write(12'h300, 32'h00000001);
      write(12'h184, $urandom);
      do_reset(1'b0);
      sweep();
      do_reset(1'b1);
      sweep();
      wrap_up();
   end
endmodule
`default_nettype wire
